/* ust_pkg.sv */
// How it works
// - one data address: read rx, write tx
// - ninth data bit used only in nine-bit mode
// - start needs three one samples then fall
// - ten or eleven bit frames, lsb first
// - length and parity bits set data content
// - idle all ones, break all zeros
// - bit rate is clock over 32 times divisor
// - divisor zero stops all baud ticks
// - receiver samples at sixteen times bit rate
// - parity type: 0 even, 1 odd
// - parity in data msb, generated and checked
// - double buffered, runs while transmit enabled
// - shifter drives pin while enabled or busy
// - open drain select applies to tx pin
// - buffer empty flag clears by status write of one, sets on move
// - complete flag clears by status read, data write
// - enabling sends idle preamble frame
// - break frames while send break is set
// - break ends with complete and mark bit
// - all done: both flags set, pin high
// - disable finishes frames, drops buffered word
// - tx pin assignable, rx pin dedicated
// - frame end loads rx buffer, sets full
package ust_pkg;
	localparam logic [7:0] REG_BAUD = 8'h00;
	localparam logic [7:0] REG_CFG  = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_DATA = 8'h0c;
	localparam logic [7:0] REG_PIN  = 8'h10;
	localparam logic [7:0] REG_DIR  = 8'h14;
	localparam int CFG_PE  = 0;
	localparam int CFG_PT  = 1;
	localparam int CFG_M   = 2;
	localparam int CFG_TE  = 3;
	localparam int CFG_RE  = 4;
	localparam int CFG_SBK = 5;
	localparam int CFG_OD  = 6;
	localparam int ST_TX_BUFFER_EMPTY = 0;
	localparam int ST_TC   = 1;
	localparam int ST_RX_BUFFER_FULL = 2;
	localparam int ST_PF   = 3;
	localparam int DIR_OUT = 0;
	localparam int DIR_VAL = 1;
	localparam int DIR_PIN = 2;
	localparam logic [12:0] BAUD_RST = 13'h0000;
	localparam logic [3:0] RT_LAST     = 4'hf;
	localparam logic [1:0] START_ONES  = 2'h3;
	localparam logic [3:0] SMP_A       = 4'h7;
	localparam logic [3:0] SMP_B       = 4'h8;
	localparam logic [3:0] SMP_C       = 4'h9;
	localparam logic [3:0] RESYNC_FROM = 4'hc;
	localparam logic [3:0] RT_EDGE     = 4'h1;
	localparam logic [3:0] INFO8       = 4'h8;
	localparam logic [3:0] INFO9       = 4'h9;
	localparam logic [3:0] LAST_M0     = 4'h9;
	localparam logic [3:0] LAST_M1     = 4'ha;
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_MARK} ust_txst_t;
	typedef enum logic [1:0] {K_IDLE, K_DATA, K_BRK} ust_kind_t;

	// parity over the bits below the data msb
	function automatic logic ust_par(
		input logic [8:0] d,
		input logic       m,
		input logic       odd
	);
		logic [8:0] k;
		k = m ? (d & 9'h0ff) : (d & 9'h07f);
		return (^k) ^ odd;
	endfunction : ust_par
endpackage : ust_pkg

/* ust_baud.sv */
`timescale 1ns/10ps
module ust_baud import ust_pkg::*; #(
	parameter int DIV_W = 13
) (
	input  wire logic             clk,      // system clock
	input  wire logic             rst_n,    // sync reset, low
	input  wire logic [DIV_W-1:0] div,      // divisor, zero stops
	output logic                  rt_tick,  // sixteen-times enable
	output logic                  bit_tick  // one-per-bit enable
);
	typedef struct packed {
		logic [DIV_W:0] cnt;
		logic [3:0]     sub;
		logic           rt;
		logic           bt;
	} ust_baud_t;
	ust_baud_t cur_ff, nxt_ff;

	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.rt = 1'b0;
		nxt_ff.bt = 1'b0;
		if (div == '0) begin
			nxt_ff.cnt = '0;
			nxt_ff.sub = '0;
		end else if (cur_ff.cnt >= {div, 1'b0} - 1'b1) begin
			nxt_ff.cnt = '0;
			nxt_ff.rt = 1'b1;
			nxt_ff.sub = cur_ff.sub + 1'b1;
			nxt_ff.bt = (cur_ff.sub == RT_LAST);
		end else begin
			nxt_ff.cnt = cur_ff.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			cur_ff <= '0;
		else
			cur_ff <= nxt_ff;
	end

	assign rt_tick  = cur_ff.rt;
	assign bit_tick = cur_ff.bt;
endmodule : ust_baud

/* ust_rxbit.sv */
`timescale 1ns/10ps
module ust_rxbit import ust_pkg::*; (
	input  wire logic       clk,      // system clock
	input  wire logic       rst_n,    // sync reset, low
	input  wire logic       rt_tick,  // sixteen-times enable
	input  wire logic       en,       // receiver enable
	input  wire logic       rxd,      // line level
	input  wire logic       nine,     // nine info bits
	output logic            done,     // frame complete pulse
	output logic [8:0]      data      // info bits, lsb aligned
);
	typedef struct packed {
		logic [1:0] ones;
		logic       prev;
		logic       busy;
		logic [3:0] rtc;
		logic [3:0] idx;
		logic [1:0] votes;
		logic [8:0] sh;
		logic       done;
	} ust_rx_t;
	ust_rx_t cur_ff, nxt_ff;
	logic    bitv;

	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.done = 1'b0;
		bitv = (cur_ff.votes + {1'b0, rxd}) >= 2'd2;
		if (!en) begin
			nxt_ff.busy = 1'b0;
			nxt_ff.ones = '0;
		end else if (rt_tick) begin
			nxt_ff.prev = rxd;
			if (!cur_ff.busy) begin
				nxt_ff.ones = !rxd ? 2'd0 :
					(cur_ff.ones == START_ONES) ? cur_ff.ones :
					cur_ff.ones + 1'b1;
				if (!rxd && cur_ff.ones == START_ONES) begin
					nxt_ff.busy = 1'b1;
					nxt_ff.rtc = '0;
					nxt_ff.idx = '0;
					nxt_ff.votes = '0;
				end
			end else begin
				nxt_ff.rtc = cur_ff.rtc + 1'b1;
				if (cur_ff.rtc == RT_LAST)
					nxt_ff.votes = '0;
				if (cur_ff.rtc == RT_LAST)
					nxt_ff.idx = cur_ff.idx + 1'b1;
				if (rxd != cur_ff.prev && cur_ff.rtc >= RESYNC_FROM
					&& cur_ff.idx != '0) begin
					nxt_ff.rtc = RT_EDGE;
					nxt_ff.idx = cur_ff.idx + 1'b1;
					nxt_ff.votes = '0;
				end else if (cur_ff.rtc == SMP_A || cur_ff.rtc == SMP_B) begin
					nxt_ff.votes = cur_ff.votes + {1'b0, rxd};
				end else if (cur_ff.rtc == SMP_C) begin
					if (cur_ff.idx == '0) begin
						nxt_ff.busy = bitv ? 1'b0 : 1'b1;
					end else if (cur_ff.idx <= (nine ? INFO9 : INFO8)) begin
						nxt_ff.sh = {bitv, cur_ff.sh[8:1]};
					end else begin
						nxt_ff.done = 1'b1;
						nxt_ff.busy = 1'b0;
						nxt_ff.ones = '0;
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			cur_ff <= '0;
		else
			cur_ff <= nxt_ff;
	end

	assign done = cur_ff.done;
	assign data = nine ? cur_ff.sh : {1'b0, cur_ff.sh[8:1]};
endmodule : ust_rxbit

/* ust_top.sv */
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/10ps
module ust_top import ust_pkg::*; #(
	parameter int DIV_W = 13
) (
	input  wire logic        MCLK,     // system clock
	input  wire logic        RST_N,    // sync reset, low
	input  wire logic        PSEL,     // apb select
	input  wire logic        PENABLE,  // apb access phase
	input  wire logic        PWRITE,   // apb direction
	input  wire logic [7:0]  PADDR,    // apb byte address
	input  wire logic [31:0] PWDATA,   // apb write data
	output logic      [31:0] PRDATA,   // apb read data
	output logic             PREADY,   // apb ready
	output logic             PSLVERR,  // unmapped address
	input  wire logic        RXD,      // serial receive pin
	input  wire logic        TXD_I,    // tx pin level
	output logic             TXD_O,    // tx pin drive value
	output logic             TXD_OE    // tx pin drive enable
);
	typedef struct packed {
		logic [DIV_W-1:0] baud;
		logic             pe;
		logic             pt;
		logic             m;
		logic             te;
		logic             re;
		logic             send_break;
		logic             od;
		logic             pin_ser;
		logic             gp_dir;
		logic             gp_val;
		logic [8:0]       transmit_buffer;
		logic             tx_buffer_empty;
		logic             tfull;
		logic             brk_pend;
		logic             tc;
		logic             tc_arm;
		logic             rx_arm;
		logic [8:0]       receive_buffer;
		logic             rx_buffer_full;
		logic             pf;
		logic             te_q;
		logic             pre_pend;
		ust_txst_t        st;
		ust_kind_t        kind;
		logic [10:0]      sh;
		logic [3:0]       cnt;
		logic             tx_bit;
		logic             txd_o;
		logic             txd_oe;
		logic             pready;
		logic [31:0]      prdata;
		logic             pslverr;
	} ust_top_t;

	ust_top_t    cur_ff, nxt_ff;
	logic        rt_tick;
	logic        bit_tick;
	logic        rx_done;
	logic [8:0]  rx_data;

	////////////////////////////////////////////////////////////////////
	// baud generator and receiver

	ust_baud #(.DIV_W(DIV_W)) u_baud (
		.clk      (MCLK),
		.rst_n    (RST_N),
		.div      (cur_ff.baud),
		.rt_tick  (rt_tick),
		.bit_tick (bit_tick)
	);

	ust_rxbit u_rx (
		.clk     (MCLK),
		.rst_n   (RST_N),
		.rt_tick (rt_tick),
		.en      (cur_ff.re),
		.rxd     (RXD),
		.nine    (cur_ff.m),
		.done    (rx_done),
		.data    (rx_data)
	);

	////////////////////////////////////////////////////////////////////
	// frame builder: start, info lsb first, stop bits

	function automatic logic [10:0] mk_frame(
		input logic [8:0] d,
		input logic       m,
		input logic       pe,
		input logic       pt
	);
		logic [8:0] v;
		v = d;
		if (pe && m)
			v[8] = ust_par(d, m, pt);
		if (pe && !m)
			v[7] = ust_par(d, m, pt);
		return m ? {1'b1, v, 1'b0} : {2'b11, v[7:0], 1'b0};
	endfunction : mk_frame

	////////////////////////////////////////////////////////////////////
	// next state

	logic       acc;
	logic       wr;
	logic       rd;
	logic       wr_dat;
	logic       mapped;
	logic       owns;
	logic       pval;
	logic       drive;
	logic [3:0] last;
	logic [31:0] rv;

	always_comb begin
		nxt_ff = cur_ff;
		acc = PSEL & PENABLE & cur_ff.pready;
		wr = acc & PWRITE;
		rd = acc & ~PWRITE;
		wr_dat = wr && PADDR == REG_DATA;
		last = cur_ff.m ? LAST_M1 : LAST_M0;
		mapped = PADDR == REG_BAUD || PADDR == REG_CFG
			|| PADDR == REG_STAT || PADDR == REG_DATA
			|| PADDR == REG_PIN || PADDR == REG_DIR;
		rv = '0;
		unique case (PADDR)
			REG_BAUD: rv = 32'(cur_ff.baud);
			REG_CFG: begin
				rv[CFG_PE] = cur_ff.pe;
				rv[CFG_PT] = cur_ff.pt;
				rv[CFG_M] = cur_ff.m;
				rv[CFG_TE] = cur_ff.te;
				rv[CFG_RE] = cur_ff.re;
				rv[CFG_SBK] = cur_ff.send_break;
				rv[CFG_OD] = cur_ff.od;
			end
			REG_STAT: begin
				rv[ST_TX_BUFFER_EMPTY] = cur_ff.tx_buffer_empty;
				rv[ST_TC] = cur_ff.tc;
				rv[ST_RX_BUFFER_FULL] = cur_ff.rx_buffer_full;
				rv[ST_PF] = cur_ff.pf;
			end
			REG_DATA: rv = 32'(cur_ff.receive_buffer);
			REG_PIN: rv[0] = cur_ff.pin_ser;
			REG_DIR: begin
				rv[DIR_OUT] = cur_ff.gp_dir;
				rv[DIR_VAL] = cur_ff.gp_val;
				rv[DIR_PIN] = TXD_I;
			end
			default: rv = '0;
		endcase

		// apb: one wait cycle, answer registered
		nxt_ff.pready = PSEL & PENABLE & ~cur_ff.pready;
		nxt_ff.prdata = (PSEL & PENABLE & ~cur_ff.pready) ? rv : '0;
		nxt_ff.pslverr = PSEL & PENABLE & ~cur_ff.pready & ~mapped;

		if (wr && PADDR == REG_BAUD)
			nxt_ff.baud = PWDATA[DIV_W-1:0];
		if (wr && PADDR == REG_CFG) begin
			nxt_ff.pe = PWDATA[CFG_PE];
			nxt_ff.pt = PWDATA[CFG_PT];
			nxt_ff.m = PWDATA[CFG_M];
			nxt_ff.te = PWDATA[CFG_TE];
			nxt_ff.re = PWDATA[CFG_RE];
			nxt_ff.send_break = PWDATA[CFG_SBK];
			nxt_ff.od = PWDATA[CFG_OD];
		end
		if (wr && PADDR == REG_PIN)
			nxt_ff.pin_ser = PWDATA[0];
		if (wr && PADDR == REG_DIR) begin
			nxt_ff.gp_dir = PWDATA[DIR_OUT];
			nxt_ff.gp_val = PWDATA[DIR_VAL];
		end

		// status read arms flag clearing
		if (rd && PADDR == REG_STAT) begin
			nxt_ff.tc_arm = cur_ff.tc;
			nxt_ff.rx_arm = cur_ff.rx_buffer_full;
		end
		if (wr && PADDR == REG_STAT && PWDATA[ST_TX_BUFFER_EMPTY])
			nxt_ff.tx_buffer_empty = 1'b0;
		if (wr_dat && !cur_ff.tx_buffer_empty) begin
			nxt_ff.transmit_buffer = PWDATA[8:0];
			nxt_ff.tfull = 1'b1;
		end
		if (wr_dat && cur_ff.tc_arm) begin
			nxt_ff.tc = 1'b0;
			nxt_ff.tc_arm = 1'b0;
		end
		if (rd && PADDR == REG_DATA && cur_ff.rx_arm) begin
			nxt_ff.rx_buffer_full = 1'b0;
			nxt_ff.pf = 1'b0;
			nxt_ff.rx_arm = 1'b0;
		end

		// receive: load buffer and flags, set wins over clear
		if (rx_done) begin
			nxt_ff.receive_buffer = cur_ff.m ? rx_data : {1'b0, rx_data[7:0]};
			nxt_ff.rx_buffer_full = 1'b1;
			nxt_ff.pf = cur_ff.pe & (ust_par(rx_data, cur_ff.m, cur_ff.pt)
				!= (cur_ff.m ? rx_data[8] : rx_data[7]));
		end

		// transmitter
		nxt_ff.te_q = cur_ff.te;
		// latch a short break request so at least one frame goes out
		if (cur_ff.send_break && !(cur_ff.st == TX_SHIFT
			&& cur_ff.kind == K_BRK))
			nxt_ff.brk_pend = 1'b1;
		if (!cur_ff.te)
			nxt_ff.brk_pend = 1'b0;
		if (cur_ff.te && !cur_ff.te_q)
			nxt_ff.pre_pend = 1'b1;
		if (bit_tick) begin
			if (cur_ff.st == TX_SHIFT && cur_ff.cnt != last) begin
				nxt_ff.sh = {1'b1, cur_ff.sh[10:1]};
				nxt_ff.tx_bit = cur_ff.sh[1];
				nxt_ff.cnt = cur_ff.cnt + 1'b1;
			end else if (cur_ff.pre_pend) begin
				nxt_ff.pre_pend = 1'b0;
				nxt_ff.st = TX_SHIFT;
				nxt_ff.kind = K_IDLE;
				nxt_ff.sh = '1;
				nxt_ff.cnt = '0;
				nxt_ff.tx_bit = 1'b1;
			end else if ((cur_ff.send_break || cur_ff.brk_pend) && cur_ff.te) begin
				nxt_ff.st = TX_SHIFT;
				nxt_ff.brk_pend = 1'b0;
				nxt_ff.kind = K_BRK;
				nxt_ff.sh = '0;
				nxt_ff.cnt = '0;
				nxt_ff.tx_bit = 1'b0;
			end else if (cur_ff.st == TX_SHIFT && cur_ff.kind == K_BRK) begin
				nxt_ff.st = TX_MARK;
				nxt_ff.tx_bit = 1'b1;
				nxt_ff.tc = 1'b1;
			end else if (cur_ff.te && cur_ff.tfull) begin
				nxt_ff.st = TX_SHIFT;
				nxt_ff.kind = K_DATA;
				nxt_ff.sh = mk_frame(cur_ff.transmit_buffer, cur_ff.m, cur_ff.pe,
					cur_ff.pt);
				nxt_ff.cnt = '0;
				nxt_ff.tx_bit = 1'b0;
				// a word written in the move cycle stays pending
				nxt_ff.tx_buffer_empty = !wr_dat;
				nxt_ff.tfull = wr_dat;
			end else begin
				nxt_ff.st = TX_IDLE;
				nxt_ff.tx_bit = 1'b1;
				nxt_ff.tc = 1'b1;
				if (!cur_ff.te && !wr_dat) begin
					nxt_ff.tx_buffer_empty = 1'b1;
					nxt_ff.tfull = 1'b0;
				end
			end
		end

		// pin: serial owns it while enabled or still shifting
		owns = cur_ff.pin_ser & (cur_ff.te | cur_ff.st != TX_IDLE);
		pval = owns ? cur_ff.tx_bit : cur_ff.gp_val;
		drive = owns | cur_ff.gp_dir;
		nxt_ff.txd_o = cur_ff.od ? 1'b0 : pval;
		nxt_ff.txd_oe = cur_ff.od ? (drive & ~pval) : drive;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			cur_ff <= '0;
			cur_ff.baud <= BAUD_RST;
			cur_ff.tx_buffer_empty <= 1'b1;
			cur_ff.tc <= 1'b1;
			cur_ff.tx_bit <= 1'b1;
			cur_ff.st <= TX_IDLE;
			cur_ff.kind <= K_IDLE;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign PRDATA  = cur_ff.prdata;
	assign PREADY  = cur_ff.pready;
	assign PSLVERR = cur_ff.pslverr;
	assign TXD_O   = cur_ff.txd_o;
	assign TXD_OE  = cur_ff.txd_oe;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	property p_div0;
		(cur_ff.baud == '0) |=> !rt_tick;
	endproperty
	a_div0: assert property (p_div0)
		else $error("baud tick with zero divisor");

	property p_rtgap;
		rt_tick |=> !rt_tick;
	endproperty
	a_rtgap: assert property (p_rtgap)
		else $error("sample ticks closer than two cycles");

	property p_bitpace;
		bit_tick |-> rt_tick;
	endproperty
	a_bitpace: assert property (p_bitpace)
		else $error("bit tick off the sample grid");

	property p_tdrlock;
		(wr_dat && cur_ff.tx_buffer_empty) |=> cur_ff.tx_buffer_empty && $stable(cur_ff.transmit_buffer);
	endproperty
	a_tdrlock: assert property (p_tdrlock)
		else $error("write with empty flag set was taken");

	property p_tdrload;
		(wr_dat && !cur_ff.tx_buffer_empty) |=>
			!cur_ff.tx_buffer_empty && cur_ff.transmit_buffer == $past(PWDATA[8:0]);
	endproperty
	a_tdrload: assert property (p_tdrload)
		else $error("buffer write lost or flag set");

	property p_tcfall;
		$fell(cur_ff.tc) |-> $past(wr_dat && cur_ff.tc_arm);
	endproperty
	a_tcfall: assert property (p_tcfall)
		else $error("complete flag cleared without sequence");

	property p_brk0;
		(cur_ff.st == TX_SHIFT && cur_ff.kind == K_BRK) |-> !cur_ff.tx_bit;
	endproperty
	a_brk0: assert property (p_brk0)
		else $error("break frame carries a one");

	property p_mark;
		(cur_ff.st == TX_MARK) |-> cur_ff.tx_bit && cur_ff.tc;
	endproperty
	a_mark: assert property (p_mark)
		else $error("no mark or complete after break");

	property p_odrv;
		(cur_ff.od && $stable(cur_ff.od) && TXD_OE) |-> !TXD_O;
	endproperty
	a_odrv: assert property (p_odrv)
		else $error("open drain pin driven high");

	property p_rxfull;
		rx_done |=> cur_ff.rx_buffer_full;
	endproperty
	a_rxfull: assert property (p_rxfull)
		else $error("frame end did not set buffer full");

	property p_pre;
		(cur_ff.te && !cur_ff.te_q) |=> cur_ff.pre_pend;
	endproperty
	a_pre: assert property (p_pre)
		else $error("enable did not queue preamble");

	c_data: cover property (cur_ff.st == TX_SHIFT && cur_ff.kind == K_DATA);
	c_brk: cover property (cur_ff.st == TX_MARK);
	c_pre: cover property (cur_ff.st == TX_SHIFT && cur_ff.kind == K_IDLE);
	c_rx: cover property (rx_done && cur_ff.pe);
endmodule : ust_top

/* ust_remote.sv */
`timescale 1ns/10ps
module ust_remote #(
	parameter int BIT = 32 // mclk cycles per bit
) (
	input  wire logic       clk,     // system clock
	input  wire logic       line,    // resolved tx line
	input  wire logic [3:0] nb,      // info bits per frame
	input  wire logic       go,      // send one frame
	input  wire logic [8:0] tx_word, // frame to send
	output logic            rxd,     // line toward the block
	output int              rx_cnt,  // frames caught
	output logic [8:0]      rx_word, // last info bits
	output logic            rx_stop  // last stop level
);
	logic prev;

	initial begin
		rxd = 1'b1;
		rx_cnt = 0;
		rx_word = '0;
		rx_stop = 1'b1;
		prev = 1'b1;
	end

	// catcher: mid-bit samples after a falling edge
	always begin : catch
		logic [8:0] w;
		@(posedge clk);
		if (prev && !line) begin
			repeat (BIT / 2) @(posedge clk);
			w = '0;
			for (int i = 0; i < nb; i++) begin
				repeat (BIT) @(posedge clk);
				w[i] = line;
			end
			repeat (BIT) @(posedge clk);
			rx_word = w;
			rx_stop = line;
			rx_cnt++;
		end
		prev = line;
	end

	// talker: start, info lsb first, stop, then idle high
	always begin : talk
		@(posedge clk);
		if (go) begin
			rxd <= 1'b0;
			for (int i = 0; i < nb; i++) begin
				repeat (BIT) @(posedge clk);
				rxd <= tx_word[i];
			end
			repeat (BIT) @(posedge clk);
			rxd <= 1'b1;
			repeat (BIT) @(posedge clk);
		end
	end
endmodule : ust_remote

/* ust_top_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) \
	begin \
		n_compared++; \
		if ((g) !== (e)) begin \
			n_fail++; \
			$display("[ERR] %s exp %h got %h", nm, e, g); \
		end \
	end
module ust_top_tb import ust_pkg::*;;
	logic        mclk = 0;
	logic        rst_n = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic [31:0] q;
	logic        pready, pslverr, txd_o, txd_oe, rxd, rx_stop, err;
	logic        go = 0;
	logic [3:0]  nb = 4'h8;
	logic [8:0]  tx_word = '0;
	logic [8:0]  rx_word;
	int          rx_cnt, nw;
	int          n_fail = 0;
	int          n_compared = 0;
	wire         line = txd_oe ? txd_o : 1'b1;

	ust_top u_ust_top (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .RXD(rxd), .TXD_I(line), .TXD_O(txd_o),
		.TXD_OE(txd_oe));
	ust_remote u_ust_remote (.clk(mclk), .line(line), .nb(nb), .go(go),
		.tx_word(tx_word), .rxd(rxd), .rx_cnt(rx_cnt),
		.rx_word(rx_word), .rx_stop(rx_stop));

	always #50 mclk = ~mclk;

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		`CHK("waits", 2, n)
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	task automatic wait_flag(input int b);
		int n;
		n = 0;
		do begin
			rd(REG_STAT);
			n++;
		end while (q[b] !== 1'b1 && n < 300);
		`CHK("flag", 1'b1, q[b])
	endtask : wait_flag

	task automatic send(input logic [8:0] d);
		rd(REG_STAT);
		wr(REG_STAT, 32'h0000_0001);
		wr(REG_DATA, 32'(d));
	endtask : send

	task automatic frame(input logic [8:0] e, input logic s);
		int c;
		c = rx_cnt;
		nw = 0;
		while (rx_cnt == c && nw < 3000) begin
			@(posedge mclk);
			nw++;
		end
		`CHK("seen", 1'b1, rx_cnt != c)
		`CHK("frame", e, rx_word)
		`CHK("stop", s, rx_stop)
	endtask : frame

	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		int c;
		rd(REG_STAT);
		`CHK("stat", 4'h3, q[3:0])
		rd(REG_BAUD);
		`CHK("baud", 13'h0000, q[12:0])
		rd(8'h40);
		`CHK("slverr", 1'b1, err)
		c = rx_cnt;
		wr(REG_PIN, 32'h0000_0001);
		wr(REG_CFG, 32'h0000_0018);
		send(9'h055);
		repeat (800) @(posedge mclk);
		`CHK("stopped", c, rx_cnt)
		wr(REG_CFG, 32'h0000_0000);
	endtask : t_reset

	task automatic t_basic();
		wr(REG_BAUD, 32'h0000_0001);
		repeat (100) @(posedge mclk);
		wr(REG_CFG, 32'h0000_0018);
		send(9'h0a5);
		rd(REG_STAT);
		`CHK("tc busy", 1'b0, q[ST_TC])
		frame(9'h0a5, 1'b1);
		`CHK("preamble", 1'b1, nw > 500)
		wait_flag(ST_TC);
		`CHK("idle", 2'h3, q[1:0])
		`CHK("mark", 2'b11, {txd_oe, line})
	endtask : t_basic

	task automatic t_dbl();
		int c;
		send(9'h03c);
		wait_flag(ST_TX_BUFFER_EMPTY);
		send(9'h0c3);
		wr(REG_DATA, 32'h0000_0099);
		rd(REG_STAT);
		`CHK("tx_buffer_empty", 1'b0, q[ST_TX_BUFFER_EMPTY])
		frame(9'h03c, 1'b1);
		frame(9'h099, 1'b1);
		wait_flag(ST_TX_BUFFER_EMPTY);
		c = rx_cnt;
		wr(REG_DATA, 32'h0000_0077);
		repeat (800) @(posedge mclk);
		`CHK("no clear", c, rx_cnt)
	endtask : t_dbl

	task automatic t_fmt();
		logic [6:0] cf[5] = '{7'h18, 7'h19, 7'h1b, 7'h1c, 7'h1f};
		logic [8:0] dw[5] = '{9'h1a5, 9'h035, 9'h035, 9'h1a5, 9'h0f3};
		logic [8:0] ex[5] = '{9'h0a5, 9'h035, 9'h0b5, 9'h1a5, 9'h1f3};
		for (int i = 0; i < 5; i++) begin
			wait_flag(ST_TC);
			nb = cf[i][CFG_M] ? 4'h9 : 4'h8;
			wr(REG_CFG, 32'(cf[i]));
			send(dw[i]);
			frame(ex[i], 1'b1);
		end
	endtask : t_fmt

	task automatic t_rx();
		wait_flag(ST_TC);
		tx_word <= 9'h15a;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		wait_flag(ST_RX_BUFFER_FULL);
		`CHK("rx_buffer_full", 1'b1, q[ST_RX_BUFFER_FULL])
		rd(REG_DATA);
		`CHK("rx9", 9'h15a, q[8:0])
		nb = 4'h8;
		wr(REG_CFG, 32'h0000_0019);
		tx_word <= 9'h0b5;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		wait_flag(ST_RX_BUFFER_FULL);
		`CHK("pf", 1'b1, q[ST_PF])
		rd(REG_DATA);
		`CHK("bit8", 1'b0, q[8])
	endtask : t_rx

	task automatic t_brk();
		wr(REG_CFG, 32'h0000_0038);
		wr(REG_CFG, 32'h0000_0018);
		frame(9'h000, 1'b0);
		`CHK("brk low", 1'b0, line)
		// let the last break bit run out before looking for the mark
		repeat (24) @(posedge mclk);
		wait_flag(ST_TC);
		`CHK("brk tc", 1'b1, q[ST_TC])
		`CHK("brk mark", 1'b1, line)
	endtask : t_brk

	task automatic t_pins();
		wr(REG_CFG, 32'h0000_0058);
		repeat (64) @(posedge mclk);
		`CHK("od", 3'b001, {txd_oe, txd_o, line})
		wr(REG_CFG, 32'h0000_0000);
		repeat (64) @(posedge mclk);
		`CHK("tx off", 1'b0, txd_oe)
		wr(REG_PIN, 32'h0000_0000);
		wr(REG_DIR, 32'h0000_0001);
		repeat (4) @(posedge mclk);
		`CHK("gpio0", 2'b10, {txd_oe, txd_o})
		rd(REG_DIR);
		`CHK("pin", 1'b0, q[DIR_PIN])
		wr(REG_DIR, 32'h0000_0003);
		repeat (4) @(posedge mclk);
		`CHK("gpio1", 2'b11, {txd_oe, txd_o})
	endtask : t_pins

	task automatic finish_test();
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test

	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_basic();
		t_dbl();
		t_fmt();
		t_rx();
		t_brk();
		t_pins();
		finish_test();
	end

	// watchdog, well past the expected run length
	initial begin
		#4000000;
		n_fail++;
		finish_test();
	end
endmodule : ust_top_tb
